/* File: core/motion_cfg_pkg.sv */
// Shared constants, types and register map for the motion and tap interrupt block
package motion_cfg_pkg;

    // ----------------------------------------
    // Register indexes (byte address = 4 * index)
    // ----------------------------------------
    localparam logic [7:0] IDX_MOTION_DURATION = 8'h27;
    localparam logic [7:0] IDX_ANYMOTION_TH = 8'h28;
    localparam logic [7:0] IDX_STILLNESS_TH = 8'h29;
    localparam logic [7:0] IDX_TAP_TIMING = 8'h2a;
    localparam logic [7:0] IDX_TAP_SAMPLES_TH = 8'h2b;
    localparam logic [7:0] IDX_CONTROL = 8'h3c;
    localparam logic [7:0] IDX_STATUS = 8'h3d;
    localparam logic [7:0] IDX_MASK = 8'h3e;

    // ----------------------------------------
    // Reset values and writable bit masks
    // ----------------------------------------
    localparam logic [7:0] RST_MOTION_DURATION = 8'h00;
    localparam logic [7:0] RST_ANYMOTION_TH = 8'h14;
    localparam logic [7:0] RST_STILLNESS_TH = 8'h14;
    localparam logic [7:0] RST_TAP_TIMING = 8'h04;
    localparam logic [7:0] RST_TAP_SAMPLES_TH = 8'h0a;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] WMASK_TAP_TIMING = 8'hc7;
    localparam logic [7:0] WMASK_TAP_SAMPLES_TH = 8'hdf;
    localparam logic [7:0] WMASK_CONTROL = 8'h0f;
    localparam logic [7:0] WMASK_IRQ = 8'h0f;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_RANGE_LSB = 0;
    localparam int CTRL_NOMO_SEL = 2;
    localparam int CTRL_LOW_POWER = 3;
    localparam int ST_ANY = 0;
    localparam int ST_SLOW = 1;
    localparam int ST_SINGLE = 2;
    localparam int ST_DOUBLE = 3;
    localparam int TAP_QUIET_BIT = 7;
    localparam int TAP_SHOCK_BIT = 6;
    localparam int TAP_SAMP_LSB = 6;
    localparam int KNOCK_THRESHOLD_CODE_SHIFT = 4;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_S = 1000;
    localparam logic [9:0] QUIET_LONG_MS = 10'h01e;
    localparam logic [9:0] QUIET_SHORT_MS = 10'h014;
    localparam logic [9:0] SHOCK_SHORT_MS = 10'h032;
    localparam logic [9:0] SHOCK_LONG_MS = 10'h04b;
    localparam logic [8:0] NOMO_MID_BASE_S = 9'h014;
    localparam logic [8:0] NOMO_HIGH_BASE_S = 9'h058;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {tap_idle, tap_shock, tap_quiet, tap_window} tap_state_e;

    typedef struct packed {
        logic valid;
        logic [11:0] mag;
    } sample_s;

endpackage

/* File: core/tick_divider.sv */
// Enable-driven divider producing a one-cycle tick every period enables
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
    parameter int WIDTH = 17
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic en,
    input wire logic [WIDTH-1:0] period,
    output logic tick
);
    logic [WIDTH-1:0] count;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= 1'b0;
            if (en)
            begin
                if (count >= period - WIDTH'(1))
                begin
                    count <= '0;
                    tick <= 1'b1;
                end
                else
                begin
                    count <= count + WIDTH'(1);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: core/motion_tap_interrupt_config.sv */
// APB register bank and trigger logic for motion, stillness and tap interrupts
// Operation
// - Slow mode: interrupt after duration-bits-3:2 plus one samples above stillness threshold
// - No-motion mode: interrupt after no sample exceeds threshold for coded delay
// - Delay seconds: 00 low4+1; 01 low4*4+20; top bit low5*8+88
// - Any-motion interrupt after slope duration plus one samples above threshold
// - Any-motion threshold step 3.91 mg doubling per wider g-range
// - Stillness threshold step 3.91 mg doubling per wider g-range
// - Quiet-time bit picks 30 ms clear, 20 ms set
// - Shock-time bit picks 50 ms clear, 75 ms set
// - Double-tap window codes give 50 to 700 ms
// - After low-power wake-up tap engine processes 2, 4, 8 or 16 samples
// - Tap threshold step 62.5 mg doubling per wider g-range
`timescale 1ns/1ps
`default_nettype none
module motion_tap_interrupt_config #(
    parameter int MS_CYCLES = motion_cfg_pkg::MS_CYCLES,
    parameter int MS_PER_S = motion_cfg_pkg::MS_PER_S
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire motion_cfg_pkg::sample_s sample,
    input wire logic wake,
    output logic irq
);
    logic [7:0] motion_duration_config;
    logic [7:0] anymotion_threshold_config;
    logic [7:0] slow_nomotion_threshold_config;
    logic [7:0] tap_timing_config;
    logic [7:0] tap_samples_threshold_config;
    logic [7:0] control;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] event_set;
    logic [7:0] index;
    logic mapped;
    logic wr;
    logic [1:0] g_range;
    logic nomo_sel;
    logic [15:0] anymotion_threshold_code;
    logic [15:0] stillness_threshold_code;
    logic [15:0] knock_threshold_code;
    logic any_above;
    logic still_above;
    logic knock_above;
    logic [2:0] any_cnt;
    logic [2:0] slow_cnt;
    logic [8:0] nomo_secs;
    logic [8:0] nomo_limit;
    logic ms_tick;
    logic s_tick;
    motion_cfg_pkg::tap_state_e tap_state;
    motion_cfg_pkg::tap_state_e next_tap_state;
    logic [9:0] tap_timer;
    logic tap_second;
    logic [4:0] tap_budget;
    logic tap_sample;

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function automatic logic [8:0] nomo_delay(input logic [5:0] code);
        logic [8:0] secs;
        secs = 9'h000;
        if (code[5])
            secs = {code[4:0], 3'h0} + motion_cfg_pkg::NOMO_HIGH_BASE_S;
        else if (code[4])
            secs = {3'h0, code[3:0], 2'h0} + motion_cfg_pkg::NOMO_MID_BASE_S;
        else
            secs = {5'h00, code[3:0]} + 9'h001;
        return secs;
    endfunction

    function automatic logic [9:0] tap_window_ms(input logic [2:0] code);
        logic [9:0] ms;
        ms = 10'h000;
        case (code)
            3'h0: ms = 10'h032;
            3'h1: ms = 10'h064;
            3'h2: ms = 10'h096;
            3'h3: ms = 10'h0c8;
            3'h4: ms = 10'h0fa;
            3'h5: ms = 10'h177;
            3'h6: ms = 10'h1f4;
            default: ms = 10'h2bc;
        endcase
        return ms;
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        return idx inside {motion_cfg_pkg::IDX_MOTION_DURATION, motion_cfg_pkg::IDX_ANYMOTION_TH,
            motion_cfg_pkg::IDX_STILLNESS_TH, motion_cfg_pkg::IDX_TAP_TIMING,
            motion_cfg_pkg::IDX_TAP_SAMPLES_TH, motion_cfg_pkg::IDX_CONTROL,
            motion_cfg_pkg::IDX_STATUS, motion_cfg_pkg::IDX_MASK};
    endfunction

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    assign index = paddr[9:2];
    assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) && is_mapped(index);
    assign wr = psel && penable && pwrite && mapped;
    assign pready = 1'b1;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (psel && !penable)
        begin
            pslverr <= !mapped;
            prdata <= 32'h0000_0000;
            if (mapped)
            begin
                unique case (index)
                    motion_cfg_pkg::IDX_MOTION_DURATION: prdata[7:0] <= motion_duration_config;
                    motion_cfg_pkg::IDX_ANYMOTION_TH: prdata[7:0] <= anymotion_threshold_config;
                    motion_cfg_pkg::IDX_STILLNESS_TH: prdata[7:0] <= slow_nomotion_threshold_config;
                    motion_cfg_pkg::IDX_TAP_TIMING: prdata[7:0] <= tap_timing_config;
                    motion_cfg_pkg::IDX_TAP_SAMPLES_TH: prdata[7:0] <= tap_samples_threshold_config;
                    motion_cfg_pkg::IDX_CONTROL: prdata[7:0] <= control;
                    motion_cfg_pkg::IDX_STATUS: prdata[7:0] <= status;
                    default: prdata[7:0] <= mask;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            motion_duration_config <= motion_cfg_pkg::RST_MOTION_DURATION;
            anymotion_threshold_config <= motion_cfg_pkg::RST_ANYMOTION_TH;
            slow_nomotion_threshold_config <= motion_cfg_pkg::RST_STILLNESS_TH;
            tap_timing_config <= motion_cfg_pkg::RST_TAP_TIMING;
            tap_samples_threshold_config <= motion_cfg_pkg::RST_TAP_SAMPLES_TH;
            control <= motion_cfg_pkg::RST_CONTROL;
            mask <= motion_cfg_pkg::RST_MASK;
        end
        else if (wr)
        begin
            if (index == motion_cfg_pkg::IDX_MOTION_DURATION)
                motion_duration_config <= pwdata[7:0];
            if (index == motion_cfg_pkg::IDX_ANYMOTION_TH)
                anymotion_threshold_config <= pwdata[7:0];
            if (index == motion_cfg_pkg::IDX_STILLNESS_TH)
                slow_nomotion_threshold_config <= pwdata[7:0];
            if (index == motion_cfg_pkg::IDX_TAP_TIMING)
                tap_timing_config <= pwdata[7:0] & motion_cfg_pkg::WMASK_TAP_TIMING;
            if (index == motion_cfg_pkg::IDX_TAP_SAMPLES_TH)
                tap_samples_threshold_config <= pwdata[7:0] & motion_cfg_pkg::WMASK_TAP_SAMPLES_TH;
            if (index == motion_cfg_pkg::IDX_CONTROL)
                control <= pwdata[7:0] & motion_cfg_pkg::WMASK_CONTROL;
            if (index == motion_cfg_pkg::IDX_MASK)
                mask <= pwdata[7:0] & motion_cfg_pkg::WMASK_IRQ;
        end
    end

    // ----------------------------------------
    // Interrupt status, write one to clear, set wins
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status <= 8'h00;
        else if (wr && index == motion_cfg_pkg::IDX_STATUS)
            status <= (status & ~pwdata[7:0]) | event_set;
        else
            status <= status | event_set;
    end

    assign irq = |(status & mask);

    // ----------------------------------------
    // Range-scaled thresholds
    // ----------------------------------------
    assign g_range = control[motion_cfg_pkg::CTRL_RANGE_LSB +: 2];
    assign nomo_sel = control[motion_cfg_pkg::CTRL_NOMO_SEL];
    assign anymotion_threshold_code = {8'h00, anymotion_threshold_config} << g_range;
    assign stillness_threshold_code = {8'h00, slow_nomotion_threshold_config} << g_range;
    assign knock_threshold_code = {11'h000, tap_samples_threshold_config[4:0]}
        << (motion_cfg_pkg::KNOCK_THRESHOLD_CODE_SHIFT + int'(g_range));
    assign any_above = sample.valid && ({4'h0, sample.mag} > anymotion_threshold_code);
    assign still_above = sample.valid && ({4'h0, sample.mag} > stillness_threshold_code);
    assign knock_above = {4'h0, sample.mag} > knock_threshold_code;
    assign nomo_limit = nomo_delay(motion_duration_config[7:2]);

    tick_divider #(.WIDTH(32)) ms_div (
        .pclk(pclk),
        .presetn(presetn),
        .en(1'b1),
        .period(32'(MS_CYCLES)),
        .tick(ms_tick)
    );

    tick_divider #(.WIDTH(32)) s_div (
        .pclk(pclk),
        .presetn(presetn),
        .en(ms_tick),
        .period(32'(MS_PER_S)),
        .tick(s_tick)
    );

    // ----------------------------------------
    // Any-motion and slow/no-motion detectors
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            any_cnt <= 3'h0;
        else if (sample.valid)
            any_cnt <= any_above ? ((any_cnt[2]) ? any_cnt : any_cnt + 3'h1) : 3'h0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            slow_cnt <= 3'h0;
        else if (sample.valid)
            slow_cnt <= still_above ? ((slow_cnt[2]) ? slow_cnt : slow_cnt + 3'h1) : 3'h0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            nomo_secs <= 9'h000;
        else if (still_above || !nomo_sel)
            nomo_secs <= 9'h000;
        else if (s_tick && nomo_secs <= nomo_limit)
            nomo_secs <= nomo_secs + 9'h001;
    end

    // ----------------------------------------
    // Tap engine
    // ----------------------------------------
    assign tap_sample = sample.valid
        && (!control[motion_cfg_pkg::CTRL_LOW_POWER] || tap_budget != 5'h00);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tap_budget <= 5'h00;
        else if (wake && control[motion_cfg_pkg::CTRL_LOW_POWER])
            tap_budget <= 5'h02 << tap_samples_threshold_config[motion_cfg_pkg::TAP_SAMP_LSB +: 2];
        else if (sample.valid && tap_budget != 5'h00)
            tap_budget <= tap_budget - 5'h01;
    end

    always_comb
    begin
        next_tap_state = tap_state;
        unique case (tap_state)
            motion_cfg_pkg::tap_idle:
                if (tap_sample && knock_above)
                    next_tap_state = motion_cfg_pkg::tap_shock;
            motion_cfg_pkg::tap_shock:
                if (ms_tick && tap_timer == 10'h000)
                    next_tap_state = tap_second ? motion_cfg_pkg::tap_idle : motion_cfg_pkg::tap_quiet;
            motion_cfg_pkg::tap_quiet:
                if (ms_tick && tap_timer == 10'h000)
                    next_tap_state = motion_cfg_pkg::tap_window;
            motion_cfg_pkg::tap_window:
                if (tap_sample && knock_above)
                    next_tap_state = motion_cfg_pkg::tap_shock;
                else if (ms_tick && tap_timer == 10'h000)
                    next_tap_state = motion_cfg_pkg::tap_idle;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tap_state <= motion_cfg_pkg::tap_idle;
            tap_timer <= 10'h000;
            tap_second <= 1'b0;
        end
        else
        begin
            tap_state <= next_tap_state;
            if (next_tap_state != tap_state)
            begin
                unique case (next_tap_state)
                    motion_cfg_pkg::tap_shock:
                        tap_timer <= tap_timing_config[motion_cfg_pkg::TAP_SHOCK_BIT]
                            ? motion_cfg_pkg::SHOCK_LONG_MS : motion_cfg_pkg::SHOCK_SHORT_MS;
                    motion_cfg_pkg::tap_quiet:
                        tap_timer <= tap_timing_config[motion_cfg_pkg::TAP_QUIET_BIT]
                            ? motion_cfg_pkg::QUIET_SHORT_MS : motion_cfg_pkg::QUIET_LONG_MS;
                    motion_cfg_pkg::tap_window:
                        tap_timer <= tap_window_ms(tap_timing_config[2:0]);
                    default:
                        tap_timer <= 10'h000;
                endcase
                tap_second <= (tap_state == motion_cfg_pkg::tap_window);
            end
            else if (ms_tick && tap_timer != 10'h000)
                tap_timer <= tap_timer - 10'h001;
        end
    end

    // ----------------------------------------
    // Event collection
    // ----------------------------------------
    always_comb
    begin
        event_set = 8'h00;
        event_set[motion_cfg_pkg::ST_ANY] = any_above && any_cnt == {1'b0, motion_duration_config[1:0]};
        event_set[motion_cfg_pkg::ST_SLOW] = nomo_sel
            ? (s_tick && !still_above && nomo_secs == nomo_limit - 9'h001)
            : (still_above && slow_cnt == {1'b0, motion_duration_config[3:2]});
        event_set[motion_cfg_pkg::ST_DOUBLE] = tap_state == motion_cfg_pkg::tap_window
            && tap_sample && knock_above;
        event_set[motion_cfg_pkg::ST_SINGLE] = tap_state == motion_cfg_pkg::tap_window
            && next_tap_state == motion_cfg_pkg::tap_idle;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_any_fire;
        @(posedge pclk) disable iff (!presetn)
        (any_above && any_cnt == {1'b0, motion_duration_config[1:0]}) |=> status[motion_cfg_pkg::ST_ANY];
    endproperty
    a_any_fire: assert property (p_any_fire) else $error("any-motion not flagged");

    property p_slow_fire;
        @(posedge pclk) disable iff (!presetn)
        (!nomo_sel && still_above && slow_cnt == {1'b0, motion_duration_config[3:2]})
            |=> status[motion_cfg_pkg::ST_SLOW];
    endproperty
    a_slow_fire: assert property (p_slow_fire) else $error("slow-motion not flagged");

    property p_nomo_restart;
        @(posedge pclk) disable iff (!presetn)
        still_above |=> nomo_secs == 9'h000;
    endproperty
    a_nomo_restart: assert property (p_nomo_restart) else $error("stillness timer not restarted");

    property p_nomo_decode;
        @(posedge pclk) disable iff (!presetn)
        motion_duration_config[7:2] == 6'h21 |-> nomo_limit == 9'h060;
    endproperty
    a_nomo_decode: assert property (p_nomo_decode) else $error("delay decode wrong");

    property p_quiet_load;
        @(posedge pclk) disable iff (!presetn)
        (tap_state == motion_cfg_pkg::tap_shock && next_tap_state == motion_cfg_pkg::tap_quiet)
            |=> tap_timer == ($past(tap_timing_config[7]) ? 10'h014 : 10'h01e);
    endproperty
    a_quiet_load: assert property (p_quiet_load) else $error("quiet time wrong");

    property p_shock_load;
        @(posedge pclk) disable iff (!presetn)
        (tap_state == motion_cfg_pkg::tap_idle && tap_sample && knock_above)
            |=> tap_state == motion_cfg_pkg::tap_shock
            && tap_timer == ($past(tap_timing_config[6]) ? 10'h04b : 10'h032);
    endproperty
    a_shock_load: assert property (p_shock_load) else $error("shock time wrong");

    property p_window_load;
        @(posedge pclk) disable iff (!presetn)
        (tap_state == motion_cfg_pkg::tap_quiet && next_tap_state == motion_cfg_pkg::tap_window
            && tap_timing_config[2:0] == 3'h5) |=> tap_timer == 10'h177;
    endproperty
    a_window_load: assert property (p_window_load) else $error("tap window wrong");

    property p_budget_load;
        @(posedge pclk) disable iff (!presetn)
        (wake && control[3] && tap_samples_threshold_config[7:6] == 2'h3) |=> tap_budget == 5'h10;
    endproperty
    a_budget_load: assert property (p_budget_load) else $error("tap sample budget wrong");
endmodule
`default_nettype wire

/* File: tb/motion_tap_interrupt_config_tb.sv */
// Self-checking testbench for the motion and tap interrupt register block
`timescale 1ns/1ps
`default_nettype none
module motion_tap_interrupt_config_tb;
    // --------------------------------
    // Signals and design
    // --------------------------------
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    motion_cfg_pkg::sample_s sample = 13'h0000;
    logic wake = 1'h0;
    logic irq;
    int err_count = 0;
    int checks = 0;
    always #5 pclk = ~pclk;
    motion_tap_interrupt_config #(.MS_CYCLES(10), .MS_PER_S(4)) u_motion_tap_interrupt_config (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample(sample), .wake(wake), .irq(irq));
    // --------------------------------
    // Shared tasks
    // --------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 16);
        if (n >= 16)
        begin
            err_count++;
            conclude();
        end
        if (!w)
            chk("prdata", {24'h0, d}, prdata);
        chk("pslverr", {31'h0, e}, {31'h0, pslverr});
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic e = 1'h0);
        bus(1'h1, idx, d, e);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] d, input logic e = 1'h0);
        bus(1'h0, idx, d, e);
    endtask
    task automatic smp(input logic [11:0] m, input int k);
        @(posedge pclk);
        repeat (k)
        begin
            sample <= {1'h1, m};
            @(posedge pclk);
        end
        sample <= 13'h0000;
    endtask
    task automatic cirq(input logic e);
        @(negedge pclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task automatic wirq(input int lo, input int hi);
        int n;
        n = 0;
        @(negedge pclk);
        while (irq !== 1'h1 && n < lo + hi)
        begin
            @(negedge pclk);
            n++;
        end
        chk("irq_delay_in_range", 32'h1, {31'h0, n >= lo && n < lo + hi});
    endtask
    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_regs;
        rd(motion_cfg_pkg::IDX_MOTION_DURATION, 8'h00);
        rd(motion_cfg_pkg::IDX_ANYMOTION_TH, 8'h14);
        rd(motion_cfg_pkg::IDX_STILLNESS_TH, 8'h14);
        rd(motion_cfg_pkg::IDX_TAP_TIMING, 8'h04);
        rd(motion_cfg_pkg::IDX_TAP_SAMPLES_TH, 8'h0a);
        rd(motion_cfg_pkg::IDX_CONTROL, 8'h00);
        rd(motion_cfg_pkg::IDX_STATUS, 8'h00);
        rd(motion_cfg_pkg::IDX_MASK, 8'h00);
        wr(motion_cfg_pkg::IDX_TAP_TIMING, 8'hff);
        rd(motion_cfg_pkg::IDX_TAP_TIMING, 8'hc7);
        wr(motion_cfg_pkg::IDX_TAP_SAMPLES_TH, 8'hff);
        rd(motion_cfg_pkg::IDX_TAP_SAMPLES_TH, 8'hdf);
        wr(motion_cfg_pkg::IDX_MOTION_DURATION, 8'h84);
        rd(motion_cfg_pkg::IDX_MOTION_DURATION, 8'h84);
        wr(8'h30, 8'h55, 1'h1);
        rd(8'h30, 8'h00, 1'h1);
        $display("test regs done");
    endtask
    task automatic t_motion;
        wr(motion_cfg_pkg::IDX_MASK, 8'h0f);
        wr(motion_cfg_pkg::IDX_MOTION_DURATION, 8'h05);
        smp(12'h015, 1);
        smp(12'h014, 1);
        smp(12'h015, 1);
        rd(motion_cfg_pkg::IDX_STATUS, 8'h00);
        cirq(1'h0);
        smp(12'h015, 1);
        rd(motion_cfg_pkg::IDX_STATUS, 8'h03);
        cirq(1'h1);
        wr(motion_cfg_pkg::IDX_STATUS, 8'h03);
        cirq(1'h0);
        wr(motion_cfg_pkg::IDX_CONTROL, 8'h01);
        smp(12'h028, 2);
        rd(motion_cfg_pkg::IDX_STATUS, 8'h00);
        smp(12'h029, 2);
        rd(motion_cfg_pkg::IDX_STATUS, 8'h03);
        wr(motion_cfg_pkg::IDX_STATUS, 8'h03);
        $display("test motion done");
    endtask
    task automatic t_still;
        wr(motion_cfg_pkg::IDX_CONTROL, 8'h04);
        wr(motion_cfg_pkg::IDX_MOTION_DURATION, 8'h40);
        smp(12'h015, 1);
        wr(motion_cfg_pkg::IDX_STATUS, 8'h0f);
        wirq(720, 120);
        rd(motion_cfg_pkg::IDX_STATUS, 8'h02);
        wr(motion_cfg_pkg::IDX_STATUS, 8'h0f);
        $display("test stillness done");
    endtask
    task automatic t_tap;
        wr(motion_cfg_pkg::IDX_CONTROL, 8'h00);
        wr(motion_cfg_pkg::IDX_ANYMOTION_TH, 8'hff);
        wr(motion_cfg_pkg::IDX_STILLNESS_TH, 8'hff);
        wr(motion_cfg_pkg::IDX_TAP_TIMING, 8'h00);
        wr(motion_cfg_pkg::IDX_TAP_SAMPLES_TH, 8'h0a);
        wr(motion_cfg_pkg::IDX_STATUS, 8'h0f);
        wr(motion_cfg_pkg::IDX_MASK, 8'h0c);
        smp(12'h0a0, 1);
        smp(12'h0a1, 1);
        wirq(1250, 150);
        rd(motion_cfg_pkg::IDX_STATUS, 8'h04);
        wr(motion_cfg_pkg::IDX_STATUS, 8'h04);
        wr(motion_cfg_pkg::IDX_TAP_TIMING, 8'hc5);
        smp(12'h0a1, 1);
        repeat (1400) @(posedge pclk);
        cirq(1'h0);
        smp(12'h0a1, 1);
        wirq(0, 4);
        rd(motion_cfg_pkg::IDX_STATUS, 8'h08);
        wr(motion_cfg_pkg::IDX_STATUS, 8'h08);
        repeat (1000) @(posedge pclk);
        wr(motion_cfg_pkg::IDX_TAP_TIMING, 8'h00);
        wr(motion_cfg_pkg::IDX_CONTROL, 8'h08);
        smp(12'h0a1, 1);
        repeat (2000) @(posedge pclk);
        cirq(1'h0);
        wr(motion_cfg_pkg::IDX_TAP_SAMPLES_TH, 8'hca);
        @(posedge pclk);
        wake <= 1'h1;
        @(posedge pclk);
        wake <= 1'h0;
        smp(12'h0a1, 1);
        wirq(1250, 150);
        rd(motion_cfg_pkg::IDX_STATUS, 8'h04);
        $display("test tap done");
    endtask
    // --------------------------------
    // Main sequence
    // --------------------------------
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_motion();
        t_still();
        t_tap();
        conclude();
    end
endmodule
`default_nettype wire
